// ### inc/rlcfg_pkg.sv
// Shared constants and types of the radio link configuration registers
package rlcfg_pkg;

   // Register offsets on the serial command address
   localparam logic [4:0] OFS_PIPE = 5'h02;
   localparam logic [4:0] OFS_WID  = 5'h03;
   localparam logic [4:0] OFS_RETR = 5'h04;
   localparam logic [4:0] OFS_CH   = 5'h05;
   localparam logic [4:0] OFS_RFS  = 5'h06;

   // Command byte layout
   localparam int CMD_WR_BIT = 5;

   // Field positions
   localparam int DLY_LSB = 4;
   localparam int CNT_LSB = 0;
   localparam int PLL_BIT = 4;
   localparam int DR_BIT  = 3;
   localparam int PWR_LSB = 1;

   // Reset values
   localparam logic [5:0] RST_PIPE = 6'h03;
   localparam logic [1:0] RST_WID  = 2'h3;
   localparam logic [3:0] RST_DLY  = 4'h0;
   localparam logic [3:0] RST_CNT  = 4'h3;
   localparam logic [6:0] RST_CH   = 7'h02;
   localparam logic       RST_PLL  = 1'h0;
   localparam logic       RST_DR   = 1'h1;
   localparam logic [1:0] RST_PWR  = 2'h3;

   // Address width codes
   localparam logic [1:0] WID_ILLEGAL = 2'h0;
   localparam int         WID_MAX_BYTES = 5;

   // Retransmit delay step
   localparam int RETX_STEP_US  = 250;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RETX_STEP_CYC = RETX_STEP_US * 1000 / CLK_PERIOD_NS;

   typedef struct packed {
      logic [5:0] pipe_en;
      logic [1:0] wid;
      logic [3:0] dly;
      logic [3:0] tries;
      logic [6:0] ch;
      logic       pll_force;
      logic       air_rate;
      logic [1:0] tx_power;
   } rlcfg_cfg_s;

endpackage

// ### rtl/rlcfg_registers.sv
// Radio link configuration registers behind the serial port
`timescale 1ns/10ps
// Summary of operation
// - Width in bits 1:0, 01/10/11 = 3/4/5 bytes, 00 illegal, reset 11.
// - Below five bytes only the low-order bytes of an address are used.
// - Retry delay in bits 7:4, reset 0, 250 us per step up to 4000 us.
// - The delay runs from the end of one transmission to the next attempt.
// - Retry count in bits 3:0, reset 3, 0 disables, N allows N retries.
// - Channel sits in bits 6:0, reset 2, with bit 7 reserved as zero.
// - Radio setup bit 4 forces synthesizer lock in test, reset 0.
// - Output power sits in bits 2:1, reset 11 for highest, 00 is lowest.
module rlcfg_registers
   import rlcfg_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = RETX_STEP_CYC,
   parameter int unsigned ADDR_BYTES  = WID_MAX_BYTES
)(
   input  wire logic                    clock_i,
   input  wire logic                    reset_n_i,
   input  wire logic                    spi_sck_i,
   input  wire logic                    spi_csn_i,
   input  wire logic                    spi_mosi_i,
   output logic                         spi_miso_o,
   output logic                         spi_miso_oe_o,
   output rlcfg_cfg_s                   cfg_o,
   input  wire logic [ADDR_BYTES*8-1:0] addr_i,
   output logic [ADDR_BYTES*8-1:0]      addr_o,
   input  wire logic [5:0]              pipe_hit_i,
   output logic [5:0]                   pipe_accept_o,
   input  wire logic                    tx_end_i,
   input  wire logic                    ack_ok_i,
   output logic                         retx_start_o,
   output logic                         retx_limit_o,
   output logic [3:0]                   retx_count_o
);

   typedef enum logic [1:0] {ST_CMD, ST_DATA, ST_DONE} rlcfg_state_e;

   rlcfg_state_e                st_reg, st_next;
   rlcfg_cfg_s                  cfg_reg, cfg_next;
   logic [4:0]                  ofs_reg, ofs_next;
   logic                        wr_reg, wr_next;
   logic                        cs_active;
   logic [7:0]                  rx_byte;
   logic                        rx_valid;
   logic [7:0]                  tx_byte;
   logic                        tx_load;
   logic [ADDR_BYTES*8-1:0]     addr_mask;
   logic [ADDR_BYTES*8-1:0]     addr_reg;
   logic [5:0]                  accept_reg;
   logic [2:0]                  width_bytes;

   ////////////////////////////////////////////////////////////////////////
   // Pin side
   rlcfg_spi_slave u_spi (
      .clock_i       (clock_i),
      .reset_n_i     (reset_n_i),
      .spi_sck_i     (spi_sck_i),
      .spi_csn_i     (spi_csn_i),
      .spi_mosi_i    (spi_mosi_i),
      .spi_miso_o    (spi_miso_o),
      .spi_miso_oe_o (spi_miso_oe_o),
      .cs_active_o   (cs_active),
      .rx_byte_o     (rx_byte),
      .rx_valid_o    (rx_valid),
      .tx_byte_i     (tx_byte),
      .tx_load_i     (tx_load)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read view; reserved bits always read zero
   function automatic logic [7:0] read_reg(input logic [4:0] ofs,
                                           input rlcfg_cfg_s c);
      logic [7:0] v;
      v = 8'h00;
      case (ofs)
         OFS_PIPE: v[5:0] = c.pipe_en;
         OFS_WID:  v[1:0] = c.wid;
         OFS_RETR: begin
            v[DLY_LSB+:4] = c.dly;
            v[CNT_LSB+:4] = c.tries;
         end
         OFS_CH:   v[6:0] = c.ch;
         OFS_RFS:  begin
            v[PLL_BIT]     = c.pll_force;
            v[DR_BIT]      = c.air_rate;
            v[PWR_LSB+:2]  = c.tx_power;
         end
         default:  v = 8'h00;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Command byte, then one data byte; further bytes are ignored
   always_comb begin
      st_next  = st_reg;
      cfg_next = cfg_reg;
      ofs_next = ofs_reg;
      wr_next  = wr_reg;
      tx_load  = 1'b0;
      tx_byte  = 8'h00;
      if (!cs_active) begin
         st_next = ST_CMD;
      end else if (rx_valid) begin
         case (st_reg)
            ST_CMD: begin
               ofs_next = rx_byte[4:0];
               wr_next  = rx_byte[CMD_WR_BIT];
               tx_load  = 1'b1;
               tx_byte  = read_reg(rx_byte[4:0], cfg_reg);
               st_next  = ST_DATA;
            end
            ST_DATA: begin
               st_next = ST_DONE;
               if (wr_reg) begin
                  case (ofs_reg)
                     OFS_PIPE: cfg_next.pipe_en = rx_byte[5:0];
                     OFS_WID: begin
                        // Illegal code would leave no width; keep old
                        if (rx_byte[1:0] != WID_ILLEGAL) begin
                           cfg_next.wid = rx_byte[1:0];
                        end
                     end
                     OFS_RETR: begin
                        cfg_next.dly   = rx_byte[DLY_LSB+:4];
                        cfg_next.tries = rx_byte[CNT_LSB+:4];
                     end
                     OFS_CH: cfg_next.ch = rx_byte[6:0];
                     OFS_RFS: begin
                        cfg_next.pll_force = rx_byte[PLL_BIT];
                        cfg_next.air_rate  = rx_byte[DR_BIT];
                        cfg_next.tx_power  = rx_byte[PWR_LSB+:2];
                     end
                     default: cfg_next = cfg_reg;
                  endcase
               end
            end
            ST_DONE: st_next = ST_DONE;
            default: st_next = ST_CMD;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_reg             <= ST_CMD;
         ofs_reg            <= 5'h00;
         wr_reg             <= 1'b0;
         cfg_reg.pipe_en    <= RST_PIPE;
         cfg_reg.wid        <= RST_WID;
         cfg_reg.dly        <= RST_DLY;
         cfg_reg.tries      <= RST_CNT;
         cfg_reg.ch         <= RST_CH;
         cfg_reg.pll_force  <= RST_PLL;
         cfg_reg.air_rate   <= RST_DR;
         cfg_reg.tx_power   <= RST_PWR;
      end else begin
         st_reg  <= st_next;
         ofs_reg <= ofs_next;
         wr_reg  <= wr_next;
         cfg_reg <= cfg_next;
      end
   end

   assign cfg_o = cfg_reg;

   ////////////////////////////////////////////////////////////////////////
   // Address trimming: bytes above the width are zeroed
   assign width_bytes = 3'(cfg_reg.wid) + 3'h2;

   for (genvar b = 0; b < ADDR_BYTES; b++) begin : g_mask
      assign addr_mask[b*8+:8] = (b < width_bytes) ? 8'hFF : 8'h00;
   end

   // Registered so the packet engine sees a clean value
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         addr_reg   <= '0;
         accept_reg <= 6'h00;
      end else begin
         addr_reg   <= addr_i & addr_mask;
         accept_reg <= pipe_hit_i & cfg_reg.pipe_en;
      end
   end

   assign addr_o        = addr_reg;
   assign pipe_accept_o = accept_reg;

   ////////////////////////////////////////////////////////////////////////
   // Retransmit timing from the retransmit setup fields
   rlcfg_retx_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_retx (
      .clock_i      (clock_i),
      .reset_n_i    (reset_n_i),
      .dly_i        (cfg_reg.dly),
      .tries_i      (cfg_reg.tries),
      .tx_end_i     (tx_end_i),
      .ack_ok_i     (ack_ok_i),
      .retx_start_o (retx_start_o),
      .retx_limit_o (retx_limit_o),
      .retx_count_o (retx_count_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_wid_legal;
      @(posedge clock_i) disable iff (!reset_n_i)
      cfg_reg.wid != WID_ILLEGAL;
   endproperty
   a_wid_legal: assert property (p_wid_legal)
      else $error("address width holds the illegal code");

   property p_wid_write;
      @(posedge clock_i) disable iff (!reset_n_i)
      (st_reg == ST_DATA && rx_valid && cs_active && wr_reg
       && ofs_reg == OFS_WID)
      |=> cfg_reg.wid == (($past(rx_byte[1:0]) == WID_ILLEGAL)
                          ? $past(cfg_reg.wid) : $past(rx_byte[1:0]));
   endproperty
   a_wid_write: assert property (p_wid_write)
      else $error("address width write not applied");

   property p_addr_trim;
      @(posedge clock_i) disable iff (!reset_n_i)
      ##1 (cfg_reg.wid == $past(cfg_reg.wid))
      |-> (addr_o >> ((32'(cfg_reg.wid) + 32'd2) * 32'd8)) == '0
          && (addr_o[23:0] == $past(addr_i[23:0]));
   endproperty
   a_addr_trim: assert property (p_addr_trim)
      else $error("address bytes above width not zeroed");

   property p_retr_write;
      @(posedge clock_i) disable iff (!reset_n_i)
      (st_reg == ST_DATA && rx_valid && cs_active && wr_reg
       && ofs_reg == OFS_RETR)
      |=> {cfg_reg.dly, cfg_reg.tries} == $past(rx_byte);
   endproperty
   a_retr_write: assert property (p_retr_write)
      else $error("retransmit setup write not applied");

   property p_ch_reserved;
      @(posedge clock_i) disable iff (!reset_n_i)
      (tx_load && rx_byte[4:0] == OFS_CH) |-> !tx_byte[7];
   endproperty
   a_ch_reserved: assert property (p_ch_reserved)
      else $error("channel reserved bit read as one");

   property p_pll_reset;
      @(posedge clock_i)
      $rose(reset_n_i) |-> !cfg_reg.pll_force;
   endproperty
   a_pll_reset: assert property (p_pll_reset)
      else $error("lock force not clear after reset");

   property p_pwr_write;
      @(posedge clock_i) disable iff (!reset_n_i)
      (st_reg == ST_DATA && rx_valid && cs_active && wr_reg
       && ofs_reg == OFS_RFS)
      |=> cfg_reg.tx_power == $past(rx_byte[2:1])
          && cfg_reg.air_rate == $past(rx_byte[DR_BIT]);
   endproperty
   a_pwr_write: assert property (p_pwr_write)
      else $error("radio setup write not applied");

   property p_pipe_accept;
      @(posedge clock_i) disable iff (!reset_n_i)
      ##1 1'b1 |-> pipe_accept_o
                   == ($past(pipe_hit_i) & $past(cfg_reg.pipe_en));
   endproperty
   a_pipe_accept: assert property (p_pipe_accept)
      else $error("disabled pipe accepted a packet");

   property p_rate_stable;
      @(posedge clock_i) disable iff (!reset_n_i)
      !rx_valid |=> $stable(cfg_reg.air_rate);
   endproperty
   a_rate_stable: assert property (p_rate_stable)
      else $error("air rate changed without a write");

   property p_ch_write;
      @(posedge clock_i) disable iff (!reset_n_i)
      (st_reg == ST_DATA && rx_valid && cs_active && wr_reg
       && ofs_reg == OFS_CH)
      |=> cfg_reg.ch == $past(rx_byte[6:0]);
   endproperty
   a_ch_write: assert property (p_ch_write)
      else $error("channel write not applied");

   property p_pipe_write;
      @(posedge clock_i) disable iff (!reset_n_i)
      (st_reg == ST_DATA && rx_valid && cs_active && wr_reg
       && ofs_reg == OFS_PIPE)
      |=> cfg_reg.pipe_en == $past(rx_byte[5:0]);
   endproperty
   a_pipe_write: assert property (p_pipe_write)
      else $error("pipe enable write not applied");

   property p_pll_write;
      @(posedge clock_i) disable iff (!reset_n_i)
      (st_reg == ST_DATA && rx_valid && cs_active && wr_reg
       && ofs_reg == OFS_RFS)
      |=> cfg_reg.pll_force == $past(rx_byte[PLL_BIT]);
   endproperty
   a_pll_write: assert property (p_pll_write)
      else $error("lock force write not applied");

endmodule

// ### rtl/rlcfg_retx_timer.sv
// Retransmit delay timer and retry counter
`timescale 1ns/10ps
module rlcfg_retx_timer
   import rlcfg_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = RETX_STEP_CYC,
   parameter int unsigned CNT_W       = 24
)(
   input  wire logic       clock_i,
   input  wire logic       reset_n_i,
   input  wire logic [3:0] dly_i,
   input  wire logic [3:0] tries_i,
   input  wire logic       tx_end_i,
   input  wire logic       ack_ok_i,
   output logic            retx_start_o,
   output logic            retx_limit_o,
   output logic [3:0]      retx_count_o
);

   logic             wait_reg, wait_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [3:0]       num_reg, num_next;
   logic             start_reg, start_next;
   logic             lim_reg, lim_next;
   logic [CNT_W-1:0] target;
   logic [CNT_W-1:0] since_reg;

   // Delay is one step per code plus one, counted from end of frame
   assign target = CNT_W'(({1'b0, dly_i} + 5'h01) * STEP_CYCLES);

   ////////////////////////////////////////////////////////////////////////
   // Wait, then retry or give up once the count is spent
   always_comb begin
      wait_next  = wait_reg;
      cnt_next   = cnt_reg;
      num_next   = num_reg;
      start_next = 1'b0;
      lim_next   = 1'b0;
      if (ack_ok_i) begin
         wait_next = 1'b0;
         num_next  = 4'h0;
      end else if (wait_reg) begin
         if (cnt_reg == target - CNT_W'(1)) begin
            wait_next = 1'b0;
            if (num_reg < tries_i) begin
               start_next = 1'b1;
               num_next   = num_reg + 4'h1;
            end else begin
               lim_next = 1'b1;
               num_next = 4'h0;
            end
         end else begin
            cnt_next = cnt_reg + CNT_W'(1);
         end
      end else if (tx_end_i) begin
         wait_next = 1'b1;
         cnt_next  = '0;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_reg  <= 1'b0;
         cnt_reg   <= '0;
         num_reg   <= 4'h0;
         start_reg <= 1'b0;
         lim_reg   <= 1'b0;
      end else begin
         wait_reg  <= wait_next;
         cnt_reg   <= cnt_next;
         num_reg   <= num_next;
         start_reg <= start_next;
         lim_reg   <= lim_next;
      end
   end

   assign retx_start_o = start_reg;
   assign retx_limit_o = lim_reg;
   assign retx_count_o = num_reg;

   ////////////////////////////////////////////////////////////////////////
   // Helper: cycles since the frame end that armed the wait
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         since_reg <= '0;
      end else if (tx_end_i && !wait_reg && !ack_ok_i) begin
         since_reg <= '0;
      end else if (since_reg != '1) begin
         since_reg <= since_reg + CNT_W'(1);
      end
   end

   property p_retx_delay;
      @(posedge clock_i) disable iff (!reset_n_i)
      retx_start_o |-> since_reg == target;
   endproperty
   a_retx_delay: assert property (p_retx_delay)
      else $error("retry not one delay after frame end");

   property p_retx_count;
      @(posedge clock_i) disable iff (!reset_n_i)
      retx_start_o |-> retx_count_o <= tries_i && retx_count_o != 4'h0;
   endproperty
   a_retx_count: assert property (p_retx_count)
      else $error("retry beyond the configured count");

endmodule

// ### rtl/rlcfg_spi_slave.sv
// Serial peripheral slave: pin sampling, byte shifting in and out
`timescale 1ns/10ps
module rlcfg_spi_slave
   import rlcfg_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       reset_n_i,
   input  wire logic       spi_sck_i,
   input  wire logic       spi_csn_i,
   input  wire logic       spi_mosi_i,
   output logic            spi_miso_o,
   output logic            spi_miso_oe_o,
   output logic            cs_active_o,
   output logic [7:0]      rx_byte_o,
   output logic            rx_valid_o,
   input  wire logic [7:0] tx_byte_i,
   input  wire logic       tx_load_i
);

   logic [2:0] pin;
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] s3_reg;
   logic [2:0] filt_reg;
   logic       sck_prev_reg;
   logic [7:0] shin_reg, shin_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] shout_reg, shout_next;
   logic       loaded_reg, loaded_next;
   logic [7:0] rxb_reg, rxb_next;
   logic       rxv_reg, rxv_next;
   logic       sck_rise, sck_fall, active;

   assign pin = {spi_sck_i, spi_csn_i, spi_mosi_i};

   ////////////////////////////////////////////////////////////////////////
   // Three flops per pin; a change counts once the last two agree
   for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clock_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            // Idle pin levels, so no false select follows reset
            s1_reg[g]   <= (g == 1) ? 1'b1 : 1'b0;
            s2_reg[g]   <= (g == 1) ? 1'b1 : 1'b0;
            s3_reg[g]   <= (g == 1) ? 1'b1 : 1'b0;
            filt_reg[g] <= (g == 1) ? 1'b1 : 1'b0;
         end else begin
            s1_reg[g]   <= pin[g];
            s2_reg[g]   <= s1_reg[g];
            s3_reg[g]   <= s2_reg[g];
            filt_reg[g] <= (s2_reg[g] == s3_reg[g]) ? s3_reg[g]
                                                    : filt_reg[g];
         end
      end
   end

   assign active   = !filt_reg[1];
   assign sck_rise = filt_reg[2] && !sck_prev_reg;
   assign sck_fall = !filt_reg[2] && sck_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // Shifting; a byte loaded after the last rise survives the next fall
   always_comb begin
      shin_next   = shin_reg;
      bit_next    = bit_reg;
      shout_next  = shout_reg;
      loaded_next = loaded_reg;
      rxb_next    = rxb_reg;
      rxv_next    = 1'b0;
      if (!active) begin
         bit_next    = 3'h0;
         shout_next  = 8'h00;
         loaded_next = 1'b0;
      end else begin
         if (sck_rise) begin
            shin_next = {shin_reg[6:0], filt_reg[0]};
            bit_next  = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
               rxb_next = {shin_reg[6:0], filt_reg[0]};
               rxv_next = 1'b1;
            end
         end
         if (sck_fall) begin
            if (loaded_reg) begin
               loaded_next = 1'b0;
            end else begin
               shout_next = {shout_reg[6:0], 1'b0};
            end
         end
         if (tx_load_i) begin
            shout_next  = tx_byte_i;
            loaded_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sck_prev_reg <= 1'b0;
         shin_reg     <= 8'h00;
         bit_reg      <= 3'h0;
         shout_reg    <= 8'h00;
         loaded_reg   <= 1'b0;
         rxb_reg      <= 8'h00;
         rxv_reg      <= 1'b0;
      end else begin
         sck_prev_reg <= filt_reg[2];
         shin_reg     <= shin_next;
         bit_reg      <= bit_next;
         shout_reg    <= shout_next;
         loaded_reg   <= loaded_next;
         rxb_reg      <= rxb_next;
         rxv_reg      <= rxv_next;
      end
   end

   assign spi_miso_o    = shout_reg[7];
   assign spi_miso_oe_o = active;
   assign cs_active_o   = active;
   assign rx_byte_o     = rxb_reg;
   assign rx_valid_o    = rxv_reg;

endmodule

// ### verif/rlcfg_host_model.sv
// Host controller model driving the serial register pins
`timescale 1ns/10ps
module rlcfg_host_model (
   input  wire logic clock_i,
   output logic      spi_sck_o,
   output logic      spi_csn_o,
   output logic      spi_mosi_o,
   input  wire logic spi_miso_i,
   input  wire logic spi_miso_oe_i
);
   logic last_q;
   logic line_w;

   // Released data line shows the inverse of its last bit
   always @(posedge clock_i) begin
      if (spi_miso_oe_i) begin
         last_q <= spi_miso_i;
      end
   end
   assign line_w = spi_miso_oe_i ? spi_miso_i : ~last_q;

   // Idle: select high, clock low
   initial begin
      spi_sck_o  = 1'b0;
      spi_csn_o  = 1'b1;
      spi_mosi_o = 1'b0;
      last_q     = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   // Ten clocks per phase, above the five-clock minimum
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                       output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      rd = 8'h00;
      spi_csn_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi_o = sh[i];
         wait_clk(10);
         spi_sck_o = 1'b1;
         rd = {rd[6:0], line_w}; // Bit stands until the next fall
         wait_clk(10);
         spi_sck_o = 1'b0;
      end
      wait_clk(10);
      spi_csn_o = 1'b1;
      spi_mosi_o = ~spi_mosi_o;
      wait_clk(10); // Gap between frames
   endtask
endmodule

// ### verif/rlcfg_registers_tb.sv
// Self-checking bench of the radio link configuration registers
`timescale 1ns/10ps
module rlcfg_registers_tb
   import rlcfg_pkg::*;
();
   localparam int STEP = 10; // Short delay step keeps the run brief
   logic        clock_i;
   logic        reset_n_i;
   logic        sck, csn, mosi, miso, miso_oe;
   rlcfg_cfg_s  cfg;
   logic [39:0] addr_in, addr_out;
   logic [5:0]  hit, acc;
   logic        tx_end, ack_ok, r_start, r_limit;
   logic [3:0]  r_count;
   logic [7:0]  rv;
   int          num_errors, num_checks, cyc, n;
   logic [23:0] wtab [7] = '{24'h02FF3F, 24'h030101, 24'h030001,
      24'h04A5A5, 24'h05FF7F, 24'h06FF1E, 24'h1FFF00};
   logic [7:0]  rtab [5] = '{8'h03, 8'h03, 8'h03, 8'h02, 8'h0E};
   logic [7:0]  xval [4] = '{8'h11, 8'h11, 8'hF0, 8'hF2};
   logic        xst  [4] = '{1'h1, 1'h0, 1'h0, 1'h1};

   rlcfg_registers #(.STEP_CYCLES(STEP), .ADDR_BYTES(5)) dut (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .spi_sck_i(sck),
      .spi_csn_i(csn), .spi_mosi_i(mosi), .spi_miso_o(miso),
      .spi_miso_oe_o(miso_oe), .cfg_o(cfg), .addr_i(addr_in),
      .addr_o(addr_out), .pipe_hit_i(hit), .pipe_accept_o(acc),
      .tx_end_i(tx_end), .ack_ok_i(ack_ok), .retx_start_o(r_start),
      .retx_limit_o(r_limit), .retx_count_o(r_count));

   rlcfg_host_model host (
      .clock_i(clock_i), .spi_sck_o(sck), .spi_csn_o(csn),
      .spi_mosi_o(mosi), .spi_miso_i(miso), .spi_miso_oe_i(miso_oe));

   always #5 clock_i = ~clock_i;

   // Hang guard, well above the expected run length
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic chk(input string nm, input logic [39:0] e,
                      input logic [39:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      host.xfer({3'h1, a}, d, dummy);
   endtask

   task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
      host.xfer({3'h0, a}, 8'h00, d);
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      clock_i = 1'b0;
      reset_n_i = 1'b0;
      addr_in = 40'h123456789A;
      hit = 6'h3F;
      tx_end = 1'b0;
      ack_ok = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      reset_n_i = 1'b1;
      host.wait_clk(2);
      chk("select idle", 40'h0, 40'(miso_oe));
      host.wait_clk(4);
      chk("cfg", {6'h03, 2'h3, 4'h0, 4'h3, 7'h02, 1'h0, 1'h1, 2'h3},
          cfg);
      for (int i = 0; i < 5; i++) begin
         rd_reg(5'(i + 2), rv);
         chk("reset read", rtab[i], rv);
      end
      $display("test reset done");
      // Reserved bits, illegal width code and unmapped offset
      for (int i = 0; i < 7; i++) begin
         wr_reg(wtab[i][20:16], wtab[i][15:8]);
         rd_reg(wtab[i][20:16], rv);
         chk("read back", wtab[i][7:0], rv);
      end
      chk("cfg", {6'h3F, 2'h1, 4'hA, 4'h5, 7'h7F, 1'h1, 1'h1, 2'h3},
          cfg);
      $display("test registers done");
      for (int w = 1; w < 4; w++) begin
         wr_reg(OFS_WID, 8'(w));
         chk("addr", 40'h123456789A & ~(40'hFFFFFFFFFF << (8 * (w + 2))),
             addr_out);
      end
      wr_reg(OFS_PIPE, 8'h15);
      chk("accept", 40'h15, 40'(acc));
      $display("test address done");
      // Delay counted from end of transmission to the next attempt
      for (int i = 0; i < 4; i++) begin
         if (i != 1) begin
            wr_reg(OFS_RETR, xval[i]);
         end
         tx_end = 1'b1;
         host.wait_clk(1);
         tx_end = 1'b0;
         n = 0;
         while (r_start !== 1'b1 && r_limit !== 1'b1 && n < 400) begin
            host.wait_clk(1);
            n++;
         end
         chk("delay", 40'((xval[i][7:4] + 1) * STEP),
             40'(n));
         chk("outcome", {38'h0, xst[i], ~xst[i]},
             {38'h0, r_start, r_limit});
         chk("count", 40'(xst[i]), 40'(r_count));
      end
      // Acknowledge inside the wait cancels the retry and clears the count
      tx_end = 1'b1;
      host.wait_clk(1);
      tx_end = 1'b0;
      host.wait_clk(5);
      ack_ok = 1'b1;
      host.wait_clk(1);
      ack_ok = 1'b0;
      n = 0;
      repeat (200) begin
         host.wait_clk(1);
         if (r_start !== 1'b0 || r_limit !== 1'b0) begin
            n++;
         end
      end
      chk("ack cancel", 40'h0, 40'(n));
      chk("ack count", 40'h0, 40'(r_count));
      $display("test retransmit done");
      final_report();
   end
endmodule
